// ==== modem_block_data_exchange.sv ====
// Block data exchange registers of a half-duplex baseband modem.
// Assumes the serial control bus front end delivers whole 16-bit words
// with one-cycle strobes, and that the modem core hands over whole blocks.
//
// Function
// - A changed transmit counter marks a new block; first word written last.
// - Both counters return to zero on any modem mode change.
// - Transmit type: 01 payload, 10 frame info, 11 info plus slow control.
// - Transmit byte count 0 to 9; codes 10 to 15 reserved.
// - Partial bytes padded with trailing zeros in both directions.
// - Word0 upper byte data 0-7, lower byte header; words 1-2 bits 8-39.
// - Device bumps the receive counter modulo 4 on each new block.
// - Receive blocks labelled with the same type codes; 00 never used.
// - Receive byte count reported 0 to 9, never a reserved code.
// - Vocoder read value returned in the low byte of receive word0.
// - In transceiver pass-through the receive low byte reads as zero.
// - Soft coding carries 18 four-bit symbols instead of 72 bits.
// - Soft nibble 0000 strongest zero up to 1111 strongest one.
// - Soft symbols in hard-bit order, symbol 0 in top nibble.
// - Tx control idle: finish held block, accept no new ones.
`timescale 1ns/1ps
module modem_block_data_exchange
   import modem_xchg_pkg::*;
   #(
      parameter int WORD_W = 16,
      parameter int ADDR_W = 8
   )
   (
      // Clock and reset
      input wire logic mclk,
      input wire logic rst,
      // Register word port
      input wire logic reg_wr,
      input wire logic reg_rd,
      input wire logic [ADDR_W-1:0] reg_addr,
      input wire logic [WORD_W-1:0] reg_wdata,
      output logic [WORD_W-1:0] reg_rdata,
      output logic reg_rvalid,
      // Fields of the modem control and programming registers
      input wire logic [3:0] modem_mode,
      input wire logic [3:0] tx_ctrl,
      input wire logic pt_byte_mode,
      input wire logic [7:0] pt_addr,
      input wire logic pt_to_transceiver,
      // Outbound block to the modem core
      output logic tx_blk_valid,
      input wire logic tx_blk_ready,
      output logic [1:0] tx_blk_type,
      output logic [3:0] tx_blk_bytes,
      output logic [TX_BITS-1:0] tx_blk_data,
      output logic tx_blk_error,
      // Inbound block from the modem core
      input wire logic rx_load,
      input wire logic rx_soft,
      input wire logic [1:0] rx_type,
      input wire logic [3:0] rx_bytes,
      input wire logic [RX_BITS-1:0] rx_data,
      // Pass-through to external vocoder or transceiver
      output logic pt_wr_valid,
      output logic pt_wr_byte,
      output logic pt_wr_to_transceiver,
      output logic [7:0] pt_wr_addr,
      output logic [WORD_W-1:0] pt_wr_data,
      input wire logic pt_rd_valid,
      input wire logic [7:0] pt_rd_data
   );

   if (WORD_W != 16 || ADDR_W != 8)
   begin : g_bad_width
      $error("modem_block_data_exchange serves only 16-bit words and 8-bit addresses");
   end

   // Byte and soft-symbol widths, counter step
   localparam int BYTE_W = 8;
   localparam int NIBBLE_W = 4;
   localparam logic [1:0] CNT_STEP = 2'd1;

   // Block geometry must agree: nine bytes, eighteen nibbles, byte plus two words out
   if (RX_BITS != BYTE_W * BLOCK_BYTES || RX_BITS != NIBBLE_W * SOFT_SYMBOLS
       || TX_BITS != BYTE_W + 2 * WORD_W)
   begin : g_bad_geometry
      $error("modem_block_data_exchange block sizes disagree with the package");
   end

   typedef struct packed {
      // Mode tracking
      op_state_t op;
      logic [3:0] mode_prev;
      // Outbound block
      logic [1:0] tx_cnt;
      logic [WORD_W-1:0] tx_w1;
      logic [WORD_W-1:0] tx_w2;
      logic tx_valid;
      logic [1:0] tx_type;
      logic [3:0] tx_bytes;
      logic [TX_BITS-1:0] tx_data;
      logic tx_err;
      // Pass-through write
      logic pt_valid;
      logic pt_byte;
      logic pt_xcvr;
      logic [7:0] pt_addr;
      logic [WORD_W-1:0] pt_data;
      // Inbound block and read port
      logic [1:0] rx_cnt;
      logic [WORD_W-1:0] rx_w0;
      logic [WORD_W-1:0] rdata;
      logic rvalid;
   } state_t;

   // Everything idle and zero; both counters start at zero
   localparam state_t S_RESET = '{
      op: ST_IDLE,
      mode_prev: MODE_IDLE,
      tx_cnt: '0,
      tx_w1: '0,
      tx_w2: '0,
      tx_valid: 1'b0,
      tx_type: TYPE_RESERVED,
      tx_bytes: BYTES_NONE,
      tx_data: '0,
      tx_err: 1'b0,
      pt_valid: 1'b0,
      pt_byte: 1'b0,
      pt_xcvr: 1'b0,
      pt_addr: '0,
      pt_data: '0,
      rx_cnt: '0,
      rx_w0: '0,
      rdata: '0,
      rvalid: 1'b0
   };

   state_t s_q;
   state_t s_d;

   // Modem mode code to operating state
   function automatic op_state_t decode_mode(input logic [3:0] m);
      case (m)
         MODE_RX, MODE_RX_CAL, MODE_RX_SAVE: decode_mode = ST_RX;
         MODE_TX: decode_mode = ST_TX;
         MODE_PASS: decode_mode = ST_PASS;
         default: decode_mode = ST_IDLE;
      endcase
   endfunction

   // Zero every byte past the count; byte 0 sits at the top
   function automatic logic [RX_BITS-1:0] pad_bytes(input logic [RX_BITS-1:0] d, input logic [3:0] n);
      logic [RX_BITS-1:0] r;
      r = d;
      for (int i = 0; i < BLOCK_BYTES; i++)
      begin
         if (4'(i) >= n)
         begin
            r[RX_BITS-1-BYTE_W*i -: BYTE_W] = '0;
         end
      end
      pad_bytes = r;
   endfunction

   logic [1:0] wr_cnt;
   logic [1:0] wr_type;
   logic [3:0] wr_bytes;
   logic [RX_BITS-1:0] tx_full;
   logic [RX_BITS-1:0] rx_padded;
   logic [3:0] rx_bytes_ok;
   logic rx_type_ok;
   logic [RX_BITS-1:0] tx_padded;
   logic tx_reject;
   logic rx_accept;

   // Header fields of the word being written
   assign wr_cnt = reg_wdata[CNT_HI:CNT_LO];
   assign wr_type = reg_wdata[TYPE_HI:TYPE_LO];
   assign wr_bytes = reg_wdata[BYTES_HI:BYTES_LO];
   // Block image in stream order, bit 0 at the top
   assign tx_full = {reg_wdata[DATA_HI:DATA_LO], s_q.tx_w1, s_q.tx_w2, {(RX_BITS-TX_BITS){1'b0}}};
   // Soft nibbles keep their hard-bit places, full count and no padding
   assign rx_bytes_ok = rx_soft ? BYTES_MAX : ((rx_bytes > BYTES_MAX) ? BYTES_MAX : rx_bytes);
   assign rx_padded = rx_soft ? rx_data : pad_bytes(rx_data, rx_bytes_ok);
   assign rx_type_ok = (rx_type != TYPE_RESERVED);
   assign rx_accept = rx_load && rx_type_ok && (s_q.op == ST_RX);

   assign tx_padded = pad_bytes(tx_full, wr_bytes);
   // Tx idle, reserved codes, or a held block the core does not take now
   assign tx_reject = (tx_ctrl == CTRL_IDLE) || (wr_type == TYPE_RESERVED) || (wr_bytes > BYTES_MAX)
      || (s_q.tx_valid && !tx_blk_ready);

   always_comb
   begin
      s_d = s_q;
      s_d.tx_err = 1'b0;
      s_d.pt_valid = 1'b0;
      s_d.rvalid = 1'b0;
      s_d.mode_prev = modem_mode;
      // Decoded state lags the mode field by one cycle
      s_d.op = decode_mode(modem_mode);

      // Core took the held block; an accepted write below sets valid again
      if (s_q.tx_valid && tx_blk_ready)
      begin
         s_d.tx_valid = 1'b0;
      end

      // Register writes
      if (reg_wr)
      begin
         case (reg_addr)
            ADDR_TX1: s_d.tx_w1 = reg_wdata;
            ADDR_TX2: s_d.tx_w2 = reg_wdata;
            ADDR_TX0:
            begin
               if (s_q.op == ST_PASS)
               begin
                  s_d.pt_valid = 1'b1;
                  s_d.pt_xcvr = pt_to_transceiver;
                  // Transceiver writes are always byte wide
                  s_d.pt_byte = pt_byte_mode | pt_to_transceiver;
                  s_d.pt_addr = pt_addr;
                  s_d.pt_data = (pt_byte_mode | pt_to_transceiver) ?
                                {8'h00, reg_wdata[PT_BYTE_HI:PT_BYTE_LO]} : reg_wdata;
               end
               else if (wr_cnt != s_q.tx_cnt)
               begin
                  s_d.tx_cnt = wr_cnt;
                  // Counter is kept even when refused, so a retry needs a fresh count
                  if (tx_reject)
                  begin
                     s_d.tx_err = 1'b1;
                  end
                  else
                  begin
                     s_d.tx_valid = 1'b1;
                     s_d.tx_type = wr_type;
                     s_d.tx_bytes = wr_bytes;
                     s_d.tx_data = tx_padded[RX_BITS-1 -: TX_BITS];
                  end
               end
            end
            default: s_d.tx_w1 = s_q.tx_w1;
         endcase
      end

      // Pass-through read result lands in word0 low byte
      // Transceiver cannot be read back; zero keeps the word defined
      if (pt_rd_valid && s_q.op == ST_PASS)
      begin
         s_d.rx_w0 = pt_to_transceiver ? {WORD_W{1'b0}} : {8'h00, pt_rd_data};
      end
      else if (rx_accept)
      begin
         s_d.rx_cnt = s_q.rx_cnt + CNT_STEP;
         s_d.rx_w0 = {rx_padded[RX_BITS-1 -: 8], s_d.rx_cnt, rx_type, rx_bytes_ok};
      end

      // Mode change clears both counters
      // Overrides same-cycle loads; a non-idle mode at reset release counts too
      if (modem_mode != s_q.mode_prev)
      begin
         s_d.tx_cnt = 2'd0;
         s_d.rx_cnt = 2'd0;
         s_d.rx_w0[CNT_HI:CNT_LO] = 2'd0;
      end

      // Register reads; write-only words read as zero
      // Data holds until the next read; valid is a one-cycle pulse
      if (reg_rd)
      begin
         s_d.rvalid = 1'b1;
         s_d.rdata = (reg_addr == ADDR_RX0) ? s_q.rx_w0 : {WORD_W{1'b0}};
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         // Constants only in the asynchronous branch
         s_q <= S_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign reg_rvalid = s_q.rvalid;
   assign tx_blk_valid = s_q.tx_valid;
   assign tx_blk_type = s_q.tx_type;
   assign tx_blk_bytes = s_q.tx_bytes;
   assign tx_blk_data = s_q.tx_data;
   assign tx_blk_error = s_q.tx_err;
   assign pt_wr_valid = s_q.pt_valid;
   assign pt_wr_byte = s_q.pt_byte;
   assign pt_wr_to_transceiver = s_q.pt_xcvr;
   assign pt_wr_addr = s_q.pt_addr;
   assign pt_wr_data = s_q.pt_data;

endmodule // modem_block_data_exchange

// ==== modem_block_data_exchange_bench.sv ====
// Self-checking bench for the block data exchange registers.
// Inputs change on the falling edge of mclk.
`timescale 1ns/1ps
module modem_block_data_exchange_bench;
   import modem_xchg_pkg::*;
   logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, stall = 1, rx_load = 0, rx_soft = 0;
   logic pt_byte_mode = 0, pt_to_transceiver = 0, pt_rd_valid = 0;
   logic [7:0] reg_addr = 0, pt_addr = 0, pt_rd_data = 0, pt_wr_addr;
   logic [15:0] reg_wdata = 0, reg_rdata, pt_wr_data;
   logic [3:0] modem_mode = MODE_TX, tx_ctrl = 4'h1, rx_bytes = 0, tx_blk_bytes;
   logic [1:0] rx_type = 0, tx_blk_type;
   logic [71:0] rx_data = 0;
   logic [39:0] tx_blk_data;
   logic reg_rvalid, tx_blk_valid, tx_blk_ready, tx_blk_error, pt_wr_valid, pt_wr_byte, pt_wr_to_transceiver;
   int err_total = 0, total_checks = 0, cycles = 0, taken;

   modem_block_data_exchange u_modem_block_data_exchange (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_rvalid, .modem_mode, .tx_ctrl, .pt_byte_mode, .pt_addr, .pt_to_transceiver,
      .tx_blk_valid, .tx_blk_ready, .tx_blk_type, .tx_blk_bytes, .tx_blk_data, .tx_blk_error, .rx_load,
      .rx_soft, .rx_type, .rx_bytes, .rx_data, .pt_wr_valid, .pt_wr_byte, .pt_wr_to_transceiver, .pt_wr_addr,
      .pt_wr_data, .pt_rd_valid, .pt_rd_data);
   modem_core_model u_modem_core_model (.mclk, .rst, .stall, .tx_blk_valid, .tx_blk_ready, .taken);

   always #4 mclk = ~mclk;

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge mclk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge mclk) reg_wr = 0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(negedge mclk) {reg_rd, reg_addr} = {1'b1, a};
      @(negedge mclk) reg_rd = 0;
      chk(reg_rvalid, 1);
      chk(reg_rdata, exp);
   endtask

   // Other words first, header word last
   task automatic tx_blk(input logic [1:0] c, t, input logic [3:0] b, input logic [7:0] h, input logic [31:0] w);
      wr(ADDR_TX1, w[31:16]);
      wr(ADDR_TX2, w[15:0]);
      wr(ADDR_TX0, {h, c, t, b});
   endtask

   task automatic rx(input logic s, input logic [1:0] t, input logic [3:0] b, input logic [7:0] d);
      @(negedge mclk) {rx_load, rx_soft, rx_type, rx_bytes, rx_data} = {1'b1, s, t, b, d, 64'h0};
      @(negedge mclk) rx_load = 0;
   endtask

   task automatic pt_rd(input logic tr, input logic [7:0] d);
      @(negedge mclk) {pt_to_transceiver, pt_rd_valid, pt_rd_data} = {tr, 1'b1, d};
      @(negedge mclk) pt_rd_valid = 0;
   endtask

   task automatic test_tx;
      tx_blk(2'd1, TYPE_PAYLOAD, 4'h2, 8'haa, 32'h12345678);
      chk({tx_blk_valid, tx_blk_bytes, tx_blk_data}, {1'b1, 4'h2, 8'haa, 8'h12, 24'h0});
      @(negedge mclk) stall = 0;
      @(negedge mclk);
      chk(tx_blk_valid, 0);
      wr(ADDR_TX0, {8'haa, 2'd1, TYPE_PAYLOAD, 4'h2});
      chk({tx_blk_valid, tx_blk_error, taken[7:0]}, {2'b00, 8'd1});
      for (int t = 1; t < 4; t++)
      begin
         tx_blk(2'(t + 1), 2'(t), BYTES_MAX, 8'h5a, 32'hc3c30ff0);
         chk({tx_blk_type, tx_blk_bytes, tx_blk_data}, {2'(t), BYTES_MAX, 40'h5ac3c30ff0});
      end
      tx_blk(2'd1, TYPE_RESERVED, 4'h1, 8'h01, 32'h0);
      chk(tx_blk_error, 1);
      tx_blk(2'd2, TYPE_PAYLOAD, 4'ha, 8'h01, 32'h0);
      chk(tx_blk_error, 1);
      stall = 1;
      tx_blk(2'd3, TYPE_FRAME_INFO, 4'h1, 8'h81, 32'hffffffff);
      tx_ctrl = CTRL_IDLE;
      wr(ADDR_TX0, {8'h00, 2'd0, TYPE_PAYLOAD, 4'h1});
      chk({tx_blk_valid, tx_blk_error, tx_blk_data}, {2'b11, 8'h81, 32'h0});
      @(negedge mclk) stall = 0;
      @(negedge mclk);
      chk(taken, 5);
   endtask

   task automatic test_rx;
      modem_mode = MODE_RX;
      rx(0, TYPE_FRAME_INFO, 4'h3, 8'hc3);
      rd(ADDR_RX0, {8'hc3, 2'd1, TYPE_FRAME_INFO, 4'h3});
      rx(0, TYPE_PAYLOAD, 4'hc, 8'h11);
      rd(ADDR_RX0, {8'h11, 2'd2, TYPE_PAYLOAD, BYTES_MAX});
      rx(0, TYPE_RESERVED, 4'h1, 8'h22);
      rd(ADDR_RX0, {8'h11, 2'd2, TYPE_PAYLOAD, BYTES_MAX});
      rx(1, TYPE_FRAME_SLOW, BYTES_NONE, 8'h7f);
      rd(ADDR_RX0, {8'h7f, 2'd3, TYPE_FRAME_SLOW, BYTES_MAX});
      modem_mode = MODE_IDLE;
      rd(ADDR_RX0, {8'h7f, 2'd0, TYPE_FRAME_SLOW, BYTES_MAX});
      modem_mode = MODE_RX_SAVE;
      rx(0, TYPE_PAYLOAD, BYTES_NONE, 8'h5a);
      rd(ADDR_RX0, {8'h00, 2'd1, TYPE_PAYLOAD, BYTES_NONE});
   endtask

   task automatic test_pt;
      {modem_mode, pt_addr, pt_byte_mode} = {MODE_PASS, 8'h3c, 1'b1};
      wr(ADDR_TX0, 16'h12ab);
      chk({pt_wr_valid, pt_wr_byte, pt_wr_addr, pt_wr_data}, {2'b11, 8'h3c, 16'h00ab});
      pt_byte_mode = 0;
      wr(ADDR_TX0, 16'hbeef);
      chk({pt_wr_valid, pt_wr_byte, pt_wr_addr, pt_wr_data}, {2'b10, 8'h3c, 16'hbeef});
      {pt_byte_mode, pt_to_transceiver} = 2'b11;
      wr(ADDR_TX0, 16'h0077);
      chk({pt_wr_valid, pt_wr_to_transceiver, pt_wr_data}, {2'b11, 16'h0077});
      pt_rd(0, 8'h5a);
      rd(ADDR_RX0, 16'h005a);
      pt_rd(1, 8'h66);
      rd(ADDR_RX0, 16'h0000);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         err_total++;
         tally_and_finish;
      end
   end

   initial
   begin
      repeat (6) @(posedge mclk);
      @(negedge mclk) rst = 0;
      test_tx;
      test_rx;
      test_pt;
      tally_and_finish;
   end
endmodule // modem_block_data_exchange_bench

// ==== modem_core_model.sv ====
// Modem core model taking outbound blocks.
// Stall holds ready low to keep a block pending.
`timescale 1ns/1ps
module modem_core_model
   (
      // Clock, reset, control
      input wire logic mclk,
      input wire logic rst,
      input wire logic stall,
      // Block handshake
      input wire logic tx_blk_valid,
      output logic tx_blk_ready,
      output int taken
   );
   assign tx_blk_ready = tx_blk_valid && !stall;
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         taken <= 0;
      else if (tx_blk_ready)
         taken <= taken + 1;
endmodule // modem_core_model

// ==== modem_xchg_pkg.sv ====
// Constants and types for the modem block data exchange registers.
// Assumes a 16-bit word-level register port behind the serial control bus.
package modem_xchg_pkg;

   // Register addresses on the control bus
   localparam logic [7:0] ADDR_TX0 = 8'hb5;
   localparam logic [7:0] ADDR_TX1 = 8'hb6;
   localparam logic [7:0] ADDR_TX2 = 8'hb7;
   localparam logic [7:0] ADDR_RX0 = 8'hb8;

   // Header field positions in the first word
   localparam int CNT_HI = 7;
   localparam int CNT_LO = 6;
   localparam int TYPE_HI = 5;
   localparam int TYPE_LO = 4;
   localparam int BYTES_HI = 3;
   localparam int BYTES_LO = 0;
   localparam int DATA_HI = 15;
   localparam int DATA_LO = 8;
   localparam int PT_BYTE_HI = 7;
   localparam int PT_BYTE_LO = 0;

   // Block type codes
   localparam logic [1:0] TYPE_RESERVED = 2'h0;
   localparam logic [1:0] TYPE_PAYLOAD = 2'h1;
   localparam logic [1:0] TYPE_FRAME_INFO = 2'h2;
   localparam logic [1:0] TYPE_FRAME_SLOW = 2'h3;

   // Byte counts
   localparam logic [3:0] BYTES_NONE = 4'h0;
   localparam logic [3:0] BYTES_MAX = 4'h9;

   // Modem mode and tx control codes
   localparam logic [3:0] MODE_IDLE = 4'h0;
   localparam logic [3:0] MODE_RX = 4'h1;
   localparam logic [3:0] MODE_TX = 4'h2;
   localparam logic [3:0] MODE_PASS = 4'h4;
   localparam logic [3:0] MODE_RX_CAL = 4'h5;
   localparam logic [3:0] MODE_RX_SAVE = 4'h9;
   localparam logic [3:0] CTRL_IDLE = 4'h0;

   // Block sizes
   localparam int TX_BITS = 40;
   localparam int RX_BITS = 72;
   localparam int BLOCK_BYTES = 9;
   localparam int SOFT_SYMBOLS = 18;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_RX = 4'b0010,
      ST_TX = 4'b0100,
      ST_PASS = 4'b1000
   } op_state_t;

endpackage

// ==== modem_xchg_sva.sv ====
// Checker for the block data exchange registers.
// Sees only the top module's ports; bound below.
`timescale 1ns/1ps
module modem_xchg_sva
   import modem_xchg_pkg::*;
   #(
      parameter int WORD_W = 16,
      parameter int ADDR_W = 8
   )
   (
      // Clock and reset
      input wire logic mclk,
      input wire logic rst,
      // Register port
      input wire logic reg_wr,
      input wire logic reg_rd,
      input wire logic [ADDR_W-1:0] reg_addr,
      input wire logic reg_rvalid,
      // Control fields
      input wire logic [3:0] modem_mode,
      input wire logic [3:0] tx_ctrl,
      input wire logic [7:0] pt_addr,
      // Outbound block
      input wire logic tx_blk_valid,
      input wire logic tx_blk_ready,
      input wire logic [1:0] tx_blk_type,
      input wire logic [3:0] tx_blk_bytes,
      input wire logic [TX_BITS-1:0] tx_blk_data,
      // Pass-through
      input wire logic pt_wr_valid,
      input wire logic pt_wr_byte,
      input wire logic [7:0] pt_wr_addr,
      input wire logic [WORD_W-1:0] pt_wr_data
   );
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
   a_tx_launch: assert property ($rose(tx_blk_valid) |->
      $past(reg_wr) && $past(reg_addr) == ADDR_TX0 && $past(tx_ctrl) != CTRL_IDLE) else $error("bad launch");
   a_tx_type_ok: assert property (tx_blk_valid |-> tx_blk_type != TYPE_RESERVED) else $error("bad type");
   a_tx_bytes_ok: assert property (tx_blk_valid |-> tx_blk_bytes <= BYTES_MAX) else $error("bad count");
   a_tx_held_stable: assert property (tx_blk_valid && !tx_blk_ready |=>
      tx_blk_valid && $stable(tx_blk_data)) else $error("held block lost");
   a_tx_zero_pad: assert property (tx_blk_valid && tx_blk_bytes <= 4'h5 |->
      (tx_blk_data << (8 * tx_blk_bytes)) == 40'h0) else $error("no padding");
   a_pt_write_addr: assert property (reg_wr && reg_addr == ADDR_TX0 && modem_mode == MODE_PASS |=>
      pt_wr_valid && pt_wr_addr == $past(pt_addr)) else $error("no pass write");
   a_pt_byte_low: assert property (pt_wr_valid && pt_wr_byte |-> pt_wr_data[15:8] == 8'h00)
      else $error("byte write upper");
endmodule // modem_xchg_sva

bind modem_block_data_exchange modem_xchg_sva #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) u_sva (.mclk, .rst,
   .reg_wr, .reg_rd, .reg_addr, .reg_rvalid, .modem_mode, .tx_ctrl, .pt_addr, .tx_blk_valid, .tx_blk_ready,
   .tx_blk_type, .tx_blk_bytes, .tx_blk_data, .pt_wr_valid, .pt_wr_byte, .pt_wr_addr, .pt_wr_data);
